//--- src/tpc_pkg.sv
// package for the timer channel 0 pin function block
package tpc_pkg;

	// register indices (plain port, word-wide data in low bits)
	localparam logic [3:0] ADDR_PIN_CONTROL_HIGH = 4'h0;
	localparam logic [3:0] ADDR_PIN_CONTROL_LOW  = 4'h1;
	localparam logic [3:0] ADDR_MODE             = 4'h2;
	localparam logic [3:0] ADDR_GENERAL_A        = 4'h3;
	localparam logic [3:0] ADDR_GENERAL_C        = 4'h4;
	localparam logic [3:0] ADDR_GENERAL_D        = 4'h5;
	localparam logic [3:0] ADDR_PIN_STATUS       = 4'h6;

	// field positions
	localparam int FIELD_A_LSB   = 0;
	localparam int FIELD_D_LSB   = 4;
	localparam int FIELD_C_LSB   = 0;
	localparam int MODE_BUF_A    = 0;
	localparam int MODE_BUF_B    = 1;
	localparam int FN_CAPTURE    = 3;
	localparam int FN_CASCADE    = 2;
	localparam int FN_BOTH_EDGES = 1;
	localparam int FN_FALLING    = 0;
	localparam int FN_INIT_LEVEL = 2;

	// reset values
	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [1:0]  MODE_RESET    = 2'h0;
	localparam logic [15:0] GENERAL_RESET = 16'hffff;

	// compare-match actions, low-order bits of a function field
	localparam logic [1:0] ACT_HOLD   = 2'h0;
	localparam logic [1:0] ACT_LOW    = 2'h1;
	localparam logic [1:0] ACT_HIGH   = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;

endpackage

//--- src/tpc_top.sv
// timer channel 0 pin function, capture and compare for registers a, c and d
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// How it works
// RULE1: compare 01: initial level, low on match
// RULE2: compare 10: initial level, high on match
// RULE3: compare 11: initial level, toggle on match
// RULE4: bit 2 picks initial level; 00 holds
// RULE5: 1000 captures on pin rising edge
// RULE6: 1001 captures on pin falling edge
// RULE7: 101x captures on both pin edges
// RULE8: 11xx takes trigger from channel 1 count
// RULE9: cascade captures on channel 1 up or down steps
// RULE10: pins low after reset until field written
// RULE11: buffer mode disables register c or d function
// RULE12: capture copies counter; match when counter equals register
module tpc_top
	import tpc_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic [3:0]       i_addr,
	input  wire logic [31:0]      i_wdata,
	input  wire logic             i_wr,
	input  wire logic             i_rd,
	output logic      [31:0]      o_rdata,
	input  wire logic [WIDTH-1:0] i_ch0_counter,
	input  wire logic             i_ch1_count_step,
	input  wire logic             i_ch0_pin_a,
	input  wire logic             i_ch0_pin_c,
	input  wire logic             i_ch0_pin_d,
	output logic                  o_ch0_pin_a,
	output logic                  o_ch0_pin_c,
	output logic                  o_ch0_pin_d,
	output logic                  o_ch0_pin_a_oe_n,
	output logic                  o_ch0_pin_c_oe_n,
	output logic                  o_ch0_pin_d_oe_n,
	output logic                  o_capture_a,
	output logic                  o_capture_c,
	output logic                  o_capture_d,
	output logic                  o_match_a,
	output logic                  o_match_c,
	output logic                  o_match_d
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [7:0]            ctrl_high;
		logic [7:0]            ctrl_low;
		logic [1:0]            mode;
		logic [2:0][WIDTH-1:0] gen;
		logic [2:0]            pin_out;
		logic [2:0]            pin_prev;
		logic [2:0]            capture;
		logic [2:0]            match;
		logic [31:0]           rdata;
	} tpc_state_t;

	tpc_state_t state;
	tpc_state_t next_state;

	logic [2:0][3:0] field;
	logic [2:0]      pin_in;
	logic [2:0]      disabled;
	logic [3:0]      fn;
	logic            edge_hit;

	assign field[0] = state.ctrl_high[FIELD_A_LSB +: 4];
	assign field[1] = state.ctrl_low[FIELD_C_LSB +: 4];
	assign field[2] = state.ctrl_low[FIELD_D_LSB +: 4];
	assign pin_in   = {i_ch0_pin_d, i_ch0_pin_c, i_ch0_pin_a};
	assign disabled = {state.mode[MODE_BUF_B], state.mode[MODE_BUF_A], 1'b0}; // [RULE11]

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state          = state;
		next_state.pin_prev = pin_in;
		next_state.capture  = 3'h0;
		next_state.match    = 3'h0;
		fn                  = 4'h0;
		edge_hit            = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			fn = field[i];
			if (!disabled[i]) // [RULE11]
			begin
				if (fn[FN_CAPTURE])
				begin
					if (fn[FN_CASCADE])
						edge_hit = i_ch1_count_step; // [RULE8] [RULE9]
					else if (fn[FN_BOTH_EDGES])
						edge_hit = pin_in[i] != state.pin_prev[i]; // [RULE7]
					else if (fn[FN_FALLING])
						edge_hit = !pin_in[i] && state.pin_prev[i]; // [RULE6]
					else
						edge_hit = pin_in[i] && !state.pin_prev[i]; // [RULE5]
					if (edge_hit)
					begin
						next_state.gen[i]     = i_ch0_counter; // [RULE12]
						next_state.capture[i] = 1'b1;
					end
				end
				else if (fn[1:0] != ACT_HOLD && i_ch0_counter == state.gen[i]) // [RULE12]
				begin
					next_state.match[i] = 1'b1;
					unique case (fn[1:0])
						ACT_LOW:    next_state.pin_out[i] = 1'b0; // [RULE1]
						ACT_HIGH:   next_state.pin_out[i] = 1'b1; // [RULE2]
						ACT_TOGGLE: next_state.pin_out[i] = !state.pin_out[i]; // [RULE3]
						default:    next_state.pin_out[i] = state.pin_out[i]; // [RULE4]
					endcase
				end
			end
		end

		// register writes; a compare field write with an action other than 00 loads the initial level
		if (i_wr)
		begin
			unique case (i_addr)
				ADDR_PIN_CONTROL_HIGH:
				begin
					next_state.ctrl_high = i_wdata[7:0];
					fn = i_wdata[FIELD_A_LSB +: 4];
					if (!fn[FN_CAPTURE] && fn[1:0] != ACT_HOLD)
						next_state.pin_out[0] = fn[FN_INIT_LEVEL]; // [RULE1] [RULE2] [RULE3] [RULE4]
				end
				ADDR_PIN_CONTROL_LOW:
				begin
					next_state.ctrl_low = i_wdata[7:0];
					fn = i_wdata[FIELD_C_LSB +: 4];
					if (!fn[FN_CAPTURE] && fn[1:0] != ACT_HOLD)
						next_state.pin_out[1] = fn[FN_INIT_LEVEL]; // [RULE4]
					fn = i_wdata[FIELD_D_LSB +: 4];
					if (!fn[FN_CAPTURE] && fn[1:0] != ACT_HOLD)
						next_state.pin_out[2] = fn[FN_INIT_LEVEL]; // [RULE4]
				end
				ADDR_MODE:      next_state.mode   = i_wdata[1:0];
				ADDR_GENERAL_A: next_state.gen[0] = i_wdata[WIDTH-1:0];
				ADDR_GENERAL_C: next_state.gen[1] = i_wdata[WIDTH-1:0];
				ADDR_GENERAL_D: next_state.gen[2] = i_wdata[WIDTH-1:0];
				default:        next_state.mode   = state.mode;
			endcase
		end

		// read data stands in the cycle after the strobe only
		next_state.rdata = 32'h0;
		if (i_rd)
		begin
			unique case (i_addr)
				ADDR_PIN_CONTROL_HIGH: next_state.rdata = {24'h0, state.ctrl_high};
				ADDR_PIN_CONTROL_LOW:  next_state.rdata = {24'h0, state.ctrl_low};
				ADDR_MODE:             next_state.rdata = {30'h0, state.mode};
				ADDR_GENERAL_A:        next_state.rdata = 32'(state.gen[0]);
				ADDR_GENERAL_C:        next_state.rdata = 32'(state.gen[1]);
				ADDR_GENERAL_D:        next_state.rdata = 32'(state.gen[2]);
				ADDR_PIN_STATUS:       next_state.rdata = {26'h0, pin_in, state.pin_out};
				default:               next_state.rdata = 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			state           <= '0;
			state.ctrl_high <= CONTROL_RESET;
			state.ctrl_low  <= CONTROL_RESET;
			state.mode      <= MODE_RESET;
			state.gen       <= {3{GENERAL_RESET[WIDTH-1:0]}};
			state.pin_out   <= 3'h0; // [RULE10]
		end
		else
			state <= next_state;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_comb
	begin
		o_rdata          = state.rdata;
		o_ch0_pin_a      = state.pin_out[0];
		o_ch0_pin_c      = state.pin_out[1];
		o_ch0_pin_d      = state.pin_out[2];
		o_ch0_pin_a_oe_n = field[0][FN_CAPTURE]; // [RULE10]
		o_ch0_pin_c_oe_n = field[1][FN_CAPTURE] || disabled[1];
		o_ch0_pin_d_oe_n = field[2][FN_CAPTURE] || disabled[2];
		o_capture_a      = state.capture[0];
		o_capture_c      = state.capture[1];
		o_capture_d      = state.capture[2];
		o_match_a        = state.match[0];
		o_match_c        = state.match[1];
		o_match_d        = state.match[2];
	end

endmodule

//--- testbench/tpc_checker.sv
// assertions on the pin function block ports
`timescale 1ns/100ps
module tpc_checker
	import tpc_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	input wire logic        i_clock,
	input wire logic        i_rst_n,
	input wire logic [3:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_ch1_count_step,
	input wire logic        i_ch0_pin_a,
	input wire logic        o_ch0_pin_a,
	input wire logic        o_ch0_pin_c,
	input wire logic        o_ch0_pin_d,
	input wire logic        o_ch0_pin_a_oe_n,
	input wire logic        o_ch0_pin_c_oe_n,
	input wire logic        o_capture_a,
	input wire logic        o_capture_c,
	input wire logic        o_match_a
);
	logic [3:0] fa;
	logic       bufa;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// ------
	// field tracking
	// ------
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			fa <= 4'h0;
		else if (i_wr && i_addr == ADDR_PIN_CONTROL_HIGH)
			fa <= i_wdata[3:0];
		if (!i_rst_n)
			bufa <= 1'b0;
		else if (i_wr && i_addr == ADDR_MODE)
			bufa <= i_wdata[MODE_BUF_A];
	end
	low_on_match_a: assert property (o_match_a && fa[1:0] == ACT_LOW |-> !o_ch0_pin_a)
		else $error("pin a not low on match");
	high_on_match_a: assert property (o_match_a && fa[1:0] == ACT_HIGH |-> o_ch0_pin_a)
		else $error("pin a not high on match");
	both_edge_a: assert property (fa[3:1] == 3'b101 && $changed(i_ch0_pin_a) |=> o_capture_a)
		else $error("no both-edge capture");
	toggle_match_a: assert property (o_match_a && fa[1:0] == ACT_TOGGLE |-> o_ch0_pin_a != $past(o_ch0_pin_a))
		else $error("pin a not toggled");
	initial_level_a: assert property (i_wr && i_addr == ADDR_PIN_CONTROL_HIGH && !i_wdata[3] && i_wdata[1:0] != ACT_HOLD |=> o_ch0_pin_a == $past(i_wdata[2]))
		else $error("initial level wrong");
	rise_capture_a: assert property (fa == 4'h8 && $rose(i_ch0_pin_a) |=> o_capture_a)
		else $error("no rising capture");
	fall_capture_a: assert property (fa == 4'h9 && $fell(i_ch0_pin_a) |=> o_capture_a)
		else $error("no falling capture");
	cascade_cap_a: assert property (fa[3:2] == 2'b11 |=> o_capture_a == $past(i_ch1_count_step))
		else $error("cascade capture wrong");
	reset_pins_a: assert property (disable iff (1'b0) !i_rst_n |=> !o_ch0_pin_a && !o_ch0_pin_c && !o_ch0_pin_d && !o_ch0_pin_a_oe_n)
		else $error("pins not low after reset");
	buffer_off_a: assert property (bufa && $past(bufa) |-> o_ch0_pin_c_oe_n && !o_capture_c)
		else $error("buffered c still active");
endmodule

//--- testbench/tpc_pins.sv
// pin wires: device drive or outside level by enable
`timescale 1ns/100ps
module tpc_pins
(
	input  wire logic [2:0] i_drive,
	input  wire logic [2:0] i_oe_n,
	input  wire logic [2:0] i_level,
	output logic      [2:0] o_wire
);
	// ------
	// wire resolution
	// ------
	always_comb
	begin
		for (int k = 0; k < 3; k++)
			o_wire[k] = i_oe_n[k] ? i_level[k] : i_drive[k];
	end
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the pin function block
`timescale 1ns/100ps
module tb_top
	import tpc_pkg::*;
;
	logic        clk, rst_n, wr, rd, stp;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata;
	logic [15:0] cnt;
	logic [2:0]  lvl, drv, oen, pins;
	int          err_total, checked, cyc;
	logic [5:0]  rows [7] = '{6'h04, 6'h09, 6'h0d, 6'h16, 6'h1b, 6'h13, 6'h1e};
	tpc_top #(.WIDTH(16)) uut (.i_clock(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ch0_counter(cnt), .i_ch1_count_step(stp),
		.i_ch0_pin_a(pins[0]), .i_ch0_pin_c(pins[1]), .i_ch0_pin_d(pins[2]),
		.o_ch0_pin_a(drv[0]), .o_ch0_pin_c(drv[1]), .o_ch0_pin_d(drv[2]),
		.o_ch0_pin_a_oe_n(oen[0]), .o_ch0_pin_c_oe_n(oen[1]), .o_ch0_pin_d_oe_n(oen[2]),
		.o_capture_a(), .o_capture_c(), .o_capture_d(), .o_match_a(), .o_match_c(), .o_match_d());
	tpc_pins pm (.i_drive(drv), .i_oe_n(oen), .i_level(lvl), .o_wire(pins));
	// ------
	// tasks
	// ------
	task automatic chk(input logic [31:0] e, input logic [31:0] s, input string n);
		checked++;
		if (s !== e)
		begin
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
			err_total++;
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [31:0] e, input string n);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(e, rdata, n);
	endtask
	task automatic cap(input logic [3:0] f, input logic l, s, input logic [15:0] c, e);
		wr_reg(ADDR_PIN_CONTROL_HIGH, {28'h0, f});
		@(posedge clk);
		cnt    <= c;
		lvl[0] <= l;
		stp    <= s;
		@(posedge clk);
		stp <= 1'b0;
		rd_reg(ADDR_GENERAL_A, {16'h0, e}, "general a");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ------
	// clock, timeout, sequence
	// ------
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			final_report();
		end
	end
	initial
	begin
		{rst_n, wr, rd, stp, addr, wdata, cnt, lvl} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk(6'h00, {oen, drv}, "reset pins");
		rd_reg(ADDR_PIN_CONTROL_HIGH, 32'h0, "control high");
		rd_reg(4'hf, 32'h0, "unmapped");
		wr_reg(ADDR_GENERAL_A, 32'h0000_0100);
		foreach (rows[k])
		begin
			wr_reg(ADDR_PIN_CONTROL_HIGH, {28'h0, rows[k][5:2]});
			#1 chk(rows[k][1], drv[0], "initial level");
			@(posedge clk) cnt <= 16'h0100;
			@(posedge clk) cnt <= 16'h0000;
			repeat (3) @(posedge clk);
			#1 chk(rows[k][0], drv[0], "match level");
		end
		$display("compare table done");
		cap(4'h8, 1'b1, 1'b0, 16'h0011, 16'h0011);
		cap(4'h8, 1'b0, 1'b0, 16'h0022, 16'h0011);
		cap(4'h9, 1'b1, 1'b0, 16'h0033, 16'h0011);
		cap(4'h9, 1'b0, 1'b0, 16'h0044, 16'h0044);
		cap(4'ha, 1'b1, 1'b0, 16'h0055, 16'h0055);
		cap(4'hb, 1'b0, 1'b0, 16'h0066, 16'h0066);
		cap(4'hc, 1'b0, 1'b1, 16'h0077, 16'h0077);
		cap(4'hf, 1'b0, 1'b0, 16'h0088, 16'h0077);
		$display("capture tests done");
		wr_reg(ADDR_MODE, 32'h1);
		wr_reg(ADDR_PIN_CONTROL_LOW, 32'h81);
		#1 chk(1'b1, oen[1], "c enable");
		@(posedge clk) lvl[2:1] <= 2'b11;
		repeat (3) @(posedge clk);
		rd_reg(ADDR_GENERAL_C, 32'h0000_ffff, "general c");
		rd_reg(ADDR_PIN_STATUS, 32'h0000_0030, "pin status");
		rd_reg(ADDR_GENERAL_D, 32'h0000_0088, "general d");
		@(posedge clk) rst_n <= 1'b0;
		@(posedge clk) rst_n <= 1'b1;
		#1 chk(6'h00, {oen, drv}, "reset pins again");
		$display("buffer and reset tests done");
		final_report();
	end
endmodule
bind tpc_top tpc_checker #(.WIDTH(WIDTH)) chk (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr,
	.i_ch1_count_step, .i_ch0_pin_a, .o_ch0_pin_a, .o_ch0_pin_c, .o_ch0_pin_d,
	.o_ch0_pin_a_oe_n, .o_ch0_pin_c_oe_n, .o_capture_a, .o_capture_c, .o_match_a);
